//--- asc_pkg.sv
// Register map, control word layout and idle values for the converter scan control block.
package asc_pkg;
  localparam logic [7:0] ASC_STAGE_OFS = 8'h00;
  localparam logic [7:0] ASC_GAIN_OFS = 8'h04;
  localparam logic [7:0] ASC_UPDATE_OFS = 8'h08;
  localparam logic [7:0] ASC_LIVE_OFS = 8'h0c;
  localparam logic [7:0] ASC_LIVE_GAIN_OFS = 8'h10;
  localparam logic [7:0] ASC_STATUS_OFS = 8'h14;
  localparam int ASC_UPDATE_BIT = 0;
  localparam int ASC_COMP_BIT = 0;

  typedef enum {ASC_R_STAGE, ASC_R_GAIN, ASC_R_UPDATE, ASC_R_LIVE, ASC_R_LIVE_GAIN,
                ASC_R_STATUS, ASC_R_NONE} asc_reg_t;

  typedef struct packed {
    logic amp_pwr;
    logic adc_pwr;
    logic vcc_ref;
    logic settle;
    logic sc_test;
    logic precharge_n;
    logic pass_gate;
    logic bg_ref;
    logic hold;
    logic gnd_sel;
    logic bypass;
    logic [2:0] neg_sel;
    logic [7:0] mux;
    logic [9:0] dac;
  } asc_ctrl_t;

  typedef struct packed {
    logic x20;
    logic x10;
    logic clk;
  } asc_gain_t;

  localparam asc_ctrl_t ASC_CTRL_IDLE = '{amp_pwr: 1'b0, adc_pwr: 1'b0, vcc_ref: 1'b0,
    settle: 1'b0, sc_test: 1'b0, precharge_n: 1'b1, pass_gate: 1'b1, bg_ref: 1'b0, hold: 1'b1,
    gnd_sel: 1'b0, bypass: 1'b1, neg_sel: 3'h0, mux: 8'h01, dac: 10'h200};
  localparam asc_gain_t ASC_GAIN_IDLE = '{x20: 1'b0, x10: 1'b0, clk: 1'b0};
endpackage

//--- asc_scan_ctrl.sv
// AHB-Lite controlled set of converter control lines with a common update strobe.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

module asc_scan_ctrl
  import asc_pkg::*;
(
  input wire logic sys_clk, // System clock, 50 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write flag.
  input wire logic [2:0] hsize, // AHB transfer size.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic comparator_out, // Comparator result from the analog side.
  output logic [9:0] conversion_code, // Digital value presented to the DAC.
  output logic [7:0] input_mux_bit, // Input multiplexer selects.
  output logic [2:0] differential_negative_select, // Negative input select.
  output logic gain_bypass_select, // Channels zero to three bypass the gain.
  output logic negative_input_ground_select, // Grounds the comparator negative input.
  output logic sample_hold, // Low samples, high holds.
  output logic bandgap_reference_select, // Bandgap as DAC reference.
  output logic gain_pass_gate_enable, // Gain stage pass gate on.
  output logic comparator_latch_precharge_n, // Comparator latch precharge, active low.
  output logic switch_cap_test_enable, // x10 stage output to channel four pin.
  output logic settle_assist, // Faster gain settling.
  output logic supply_reference_select, // Supply as converter reference.
  output logic converter_power_on, // Converter power.
  output logic gain_stage_power_on, // Gain stage power.
  output logic gain_clock, // Switched-cap gain stage clock.
  output logic gain_x10_enable, // x10 gain enable.
  output logic gain_x20_enable // x20 gain enable.
);

  typedef struct packed {
    logic wr_pend;
    asc_reg_t wr_reg;
    logic [31:0] rdata;
    asc_ctrl_t stage;
    asc_gain_t stage_gain;
    asc_ctrl_t live;
    asc_gain_t live_gain;
    logic upd;
    logic comp_meta;
    logic comp_sync;
  } asc_state_t;

  localparam asc_state_t ASC_STATE_RST = '{wr_pend: 1'b0, wr_reg: ASC_R_NONE, rdata: 32'h0,
    stage: ASC_CTRL_IDLE, stage_gain: ASC_GAIN_IDLE, live: ASC_CTRL_IDLE,
    live_gain: ASC_GAIN_IDLE, upd: 1'b0, comp_meta: 1'b0, comp_sync: 1'b0};

  asc_state_t state_r;
  asc_state_t state_nxt;

  function automatic asc_reg_t asc_decode(input logic [31:0] addr);
    asc_reg_t r;
    r = ASC_R_NONE;
    if (addr[31:8] == 24'h0) begin
      unique case (addr[7:0])
        ASC_STAGE_OFS: r = ASC_R_STAGE;
        ASC_GAIN_OFS: r = ASC_R_GAIN;
        ASC_UPDATE_OFS: r = ASC_R_UPDATE;
        ASC_LIVE_OFS: r = ASC_R_LIVE;
        ASC_LIVE_GAIN_OFS: r = ASC_R_LIVE_GAIN;
        ASC_STATUS_OFS: r = ASC_R_STATUS;
        default: r = ASC_R_NONE;
      endcase
    end
    return r;
  endfunction

  logic addr_ok;
  asc_reg_t addr_reg;
  assign addr_ok = hsel && hready && htrans[1];
  assign addr_reg = asc_decode(haddr);

  always_comb begin
    state_nxt = state_r;
    state_nxt.upd = 1'b0;
    state_nxt.comp_meta = comparator_out;
    state_nxt.comp_sync = state_r.comp_meta;
    // Data phase of a write: staging registers take the word, update copies them.
    if (state_r.wr_pend) begin
      unique case (state_r.wr_reg)
        ASC_R_STAGE: state_nxt.stage = asc_ctrl_t'(hwdata);
        ASC_R_GAIN: state_nxt.stage_gain = asc_gain_t'(hwdata[2:0]);
        ASC_R_UPDATE: state_nxt.upd = hwdata[ASC_UPDATE_BIT];
        default: state_nxt.upd = 1'b0;
      endcase
    end
    // Every line moves on the same edge so no transient mix of old and new settings
    // reaches the analog switches, which could short two reference paths.
    if (state_r.upd) begin
      state_nxt.live = state_r.stage;
      state_nxt.live_gain = state_r.stage_gain;
    end
    state_nxt.wr_pend = addr_ok && hwrite;
    state_nxt.wr_reg = addr_reg;
    if (addr_ok && !hwrite) begin
      unique case (addr_reg)
        ASC_R_STAGE: state_nxt.rdata = state_r.stage;
        ASC_R_GAIN: state_nxt.rdata = {29'h0, state_r.stage_gain};
        ASC_R_LIVE: state_nxt.rdata = state_r.live;
        ASC_R_LIVE_GAIN: state_nxt.rdata = {29'h0, state_r.live_gain};
        ASC_R_STATUS: state_nxt.rdata = {31'h0, state_r.comp_sync} << ASC_COMP_BIT;
        default: state_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ASC_STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hrdata = state_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conversion_code = state_r.live.dac;
  assign input_mux_bit = state_r.live.mux;
  assign differential_negative_select = state_r.live.neg_sel;
  assign gain_bypass_select = state_r.live.bypass;
  assign negative_input_ground_select = state_r.live.gnd_sel;
  assign sample_hold = state_r.live.hold;
  assign bandgap_reference_select = state_r.live.bg_ref;
  assign gain_pass_gate_enable = state_r.live.pass_gate;
  assign comparator_latch_precharge_n = state_r.live.precharge_n;
  assign switch_cap_test_enable = state_r.live.sc_test;
  assign settle_assist = state_r.live.settle;
  assign supply_reference_select = state_r.live.vcc_ref;
  assign converter_power_on = state_r.live.adc_pwr;
  assign gain_stage_power_on = state_r.live.amp_pwr;
  assign gain_clock = state_r.live_gain.clk;
  assign gain_x10_enable = state_r.live_gain.x10;
  assign gain_x20_enable = state_r.live_gain.x20;

  AST_IDLE_CODE: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> conversion_code == 10'h200) else $error("code not midpoint after reset");
  AST_IDLE_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> gain_bypass_select && gain_pass_gate_enable)
    else $error("bypass or pass gate not idle after reset");
  AST_IDLE_GND: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !negative_input_ground_select && differential_negative_select == 3'h0)
    else $error("negative input not idle after reset");
  AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> sample_hold && comparator_latch_precharge_n)
    else $error("hold or precharge not idle after reset");
  AST_IDLE_REF: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !bandgap_reference_select && !supply_reference_select && !gain_clock)
    else $error("reference selects not idle after reset");
  AST_IDLE_PWR: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !converter_power_on && !gain_stage_power_on && !switch_cap_test_enable)
    else $error("power or test not idle after reset");
  AST_IDLE_GAIN: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> !gain_x10_enable && !gain_x20_enable && !settle_assist)
    else $error("gain selects not idle after reset");
  AST_IDLE_MUX: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> input_mux_bit == ASC_CTRL_IDLE.mux)
    else $error("input mux not idle after reset");
  AST_UPD_APPLY: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.wr_pend && state_r.wr_reg == ASC_R_UPDATE && hwdata[ASC_UPDATE_BIT]
    |=> ##1 (state_r.live == $past(state_r.stage)))
    else $error("update did not apply staged word");
  AST_NO_UPD_STABLE: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(state_r.upd) |-> $stable(state_r.live) && $stable(state_r.live_gain))
    else $error("lines moved without update");
  AST_PRECHARGE_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd && !state_r.stage.precharge_n |=> !comparator_latch_precharge_n)
    else $error("precharge request not applied");
  AST_APPLY_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> gain_bypass_select == $past(state_r.stage.bypass))
    else $error("bypass select not applied");
  AST_APPLY_GROUND: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> negative_input_ground_select == $past(state_r.stage.gnd_sel))
    else $error("ground select not applied");
  AST_APPLY_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> sample_hold == $past(state_r.stage.hold))
    else $error("sample hold not applied");
  AST_APPLY_BANDGAP: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> bandgap_reference_select == $past(state_r.stage.bg_ref))
    else $error("bandgap select not applied");
  AST_APPLY_NEG: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> differential_negative_select == $past(state_r.stage.neg_sel))
    else $error("negative select not applied");
  AST_APPLY_PASS: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> gain_pass_gate_enable == $past(state_r.stage.pass_gate))
    else $error("pass gate not applied");
  AST_APPLY_TEST: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> switch_cap_test_enable == $past(state_r.stage.sc_test))
    else $error("switch cap test not applied");
  AST_APPLY_SUPPLY: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> supply_reference_select == $past(state_r.stage.vcc_ref))
    else $error("supply reference not applied");
  AST_APPLY_POWER: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> converter_power_on == $past(state_r.stage.adc_pwr))
    else $error("converter power not applied");
  AST_APPLY_GAIN_PWR: assert property (@(posedge sys_clk) disable iff (rst)
    state_r.upd |=> gain_stage_power_on == $past(state_r.stage.amp_pwr))
    else $error("gain power not applied");
  // Both edges must see reset low, else the pair was cleared and the latency does not apply.
  AST_COMP_SYNC: assert property (@(posedge sys_clk) disable iff (rst)
    (!rst ##1 !rst) |=> (state_r.comp_sync == $past(comparator_out, 2)))
    else $error("comparator sync latency wrong");

  COV_UPDATE: cover property (@(posedge sys_clk) disable iff (rst) state_r.upd);
  COV_SAMPLE: cover property (@(posedge sys_clk) disable iff (rst) !sample_hold);
  COV_STATUS_READ: cover property (@(posedge sys_clk) disable iff (rst)
    addr_ok && !hwrite && addr_reg == ASC_R_STATUS);
  COV_GAIN_CLOCK: cover property (@(posedge sys_clk) disable iff (rst)
    gain_clock && gain_stage_power_on);
  COV_PRECHARGE: cover property (@(posedge sys_clk) disable iff (rst)
    !comparator_latch_precharge_n);
endmodule

//--- asc_adc_model.sv
// Behavioural converter comparator that answers the applied conversion code.
`timescale 1ns/1ns
module asc_adc_model #(
  parameter logic [9:0] LEVEL = 10'h180 // Analog input level in code steps.
) (
  input wire logic converter_power_on, // Converter supply.
  input wire logic [9:0] conversion_code, // Code applied to the DAC.
  output logic comparator_out // High while powered and the input lies above the DAC level.
);
  // An unpowered converter rests low so a stale result never shows.
  assign comparator_out = converter_power_on && (LEVEL > conversion_code);
endmodule

//--- asc_scan_ctrl_tb.sv
// Self-checking bench for the converter scan control block.
`timescale 1ns/1ns
module asc_scan_ctrl_tb;
  import asc_pkg::*;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, comparator_out;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w, g;
  logic [9:0] conversion_code;
  logic [7:0] input_mux_bit;
  logic [2:0] differential_negative_select;
  logic gain_bypass_select, negative_input_ground_select, sample_hold, bandgap_reference_select;
  logic gain_pass_gate_enable, comparator_latch_precharge_n, switch_cap_test_enable;
  logic settle_assist, supply_reference_select, converter_power_on, gain_stage_power_on;
  logic gain_clock, gain_x10_enable, gain_x20_enable;
  logic [31:0] stage_m = 32'h06a00600, live_m = 32'h06a00600, gain_m = 0, lgain_m = 0;
  logic [31:0] hist_q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  wire [31:0] live_w = {gain_stage_power_on, converter_power_on, supply_reference_select,
    settle_assist, switch_cap_test_enable, comparator_latch_precharge_n, gain_pass_gate_enable,
    bandgap_reference_select, sample_hold, negative_input_ground_select, gain_bypass_select,
    differential_negative_select, input_mux_bit, conversion_code};
  wire [31:0] gain_w = {29'h0, gain_x20_enable, gain_x10_enable, gain_clock};
  asc_scan_ctrl dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comparator_out, .conversion_code,
    .input_mux_bit, .differential_negative_select, .gain_bypass_select,
    .negative_input_ground_select, .sample_hold, .bandgap_reference_select,
    .gain_pass_gate_enable, .comparator_latch_precharge_n, .switch_cap_test_enable,
    .settle_assist, .supply_reference_select, .converter_power_on, .gain_stage_power_on,
    .gain_clock, .gain_x10_enable, .gain_x20_enable);
  asc_adc_model #(.LEVEL(10'h180)) adc (.converter_power_on, .conversion_code, .comparator_out);
  always #10 sys_clk = ~sys_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address phase held until hready, then data phase held until hready again.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask
  // Loads both staging words, checks the lines stay put, then applies them together.
  task automatic apply(input logic [31:0] cw, input logic [31:0] gw);
    bus(1'b1, ASC_STAGE_OFS, cw);
    stage_m = cw;
    bus(1'b1, ASC_GAIN_OFS, gw);
    gain_m = {29'h0, gw[2:0]};
    repeat (2) @(posedge sys_clk);
    chk("lines before update", live_w, live_m);
    bus(1'b1, ASC_UPDATE_OFS, 32'h1);
    live_m = stage_m;
    lgain_m = gain_m;
    hist_q.push_back(live_m);
    repeat (3) @(posedge sys_clk);
    chk("lines", live_w, live_m);
    chk("gain lines", gain_w, lgain_m);
    rdchk("stage", ASC_STAGE_OFS, stage_m);
    rdchk("live", ASC_LIVE_OFS, live_m);
    rdchk("live gain", ASC_LIVE_GAIN_OFS, lgain_m);
    rdchk("status", ASC_STATUS_OFS, {31'h0, live_m[30] && (10'h180 > live_m[9:0])});
  endtask
  initial begin
    void'($urandom(32'h8100c588));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("idle lines", live_w, 32'h06a00600);
    chk("idle gain", gain_w, 32'h0);
    rdchk("idle stage", ASC_STAGE_OFS, 32'h06a00600);
    rdchk("idle live", ASC_LIVE_OFS, 32'h06a00600);
    $display("test reset done");
    // Powered measurement on mux select 0x08 below and above the analog level, idle bits otherwise.
    apply(32'h46a02123, 32'h0);
    apply(32'h46a021c3, 32'h0);
    $display("test compare done");
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      g = $urandom();
      w[28] = 1'b0;
      if (!w[30]) begin
        w[7:0] = 8'h00;
        g[0] = 1'b0;
      end
      // With the gain stage powered, hold only moves while the gain clock stands high before and after the update.
      if (w[31] && !(g[0] && lgain_m[0])) w[23] = live_m[23];
      apply(w, g);
    end
    $display("test random done");
    bus(1'b1, ASC_LIVE_OFS, ~live_m);
    rdchk("read-only live", ASC_LIVE_OFS, live_m);
    rdchk("update reads zero", ASC_UPDATE_OFS, 32'h0);
    rdchk("unmapped", 8'h18, 32'h0);
    $display("test map done");
    // A reset in mid-run must bring every line and both staging words back to idle.
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    stage_m = 32'h06a00600;
    live_m = stage_m;
    gain_m = 0;
    lgain_m = 0;
    chk("reset lines", live_w, live_m);
    chk("reset gain", gain_w, lgain_m);
    rdchk("reset stage", ASC_STAGE_OFS, stage_m);
    rdchk("reset gain stage", ASC_GAIN_OFS, gain_m);
    $display("test second reset done");
    // Back to the idle set: code at midpoint 0x200, gain clock and settle assist off.
    apply(32'h06a00600, 32'h0);
    chk("applied count", hist_q.size(), 32'd9);
    $display("test idle done");
    finish_test();
  end
endmodule
